// file: include/pgp_pkg.sv
package pgp_pkg;
  localparam int NPIN = 2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [15:0] PIN2_CTRL_OFS = 16'h4039;
  localparam logic [15:0] PIN3_CTRL_OFS = 16'h403a;
  localparam logic [15:0] IRQ_STATUS_OFS = 16'h4040;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h4041;
  localparam logic [15:0] PIN_LEVEL_OFS = 16'h4042;

  // Control register fields
  localparam int DIR_POS = 15;
  localparam int PULL_MSB = 14;
  localparam int PULL_LSB = 13;
  localparam int IRQ_MODE_POS = 12;
  localparam int DOMAIN_POS = 11;
  localparam int POL_POS = 10;
  localparam int OD_POS = 9;
  localparam int ENA_POS = 7;
  localparam int FN_MSB = 3;
  localparam int FN_LSB = 0;
  localparam logic [15:0] CTRL_RST = 16'ha400;
  localparam logic [15:0] CTRL_WMASK = 16'hfe8f;

  // Level register fields
  localparam int SW_OUT_LSB = 0;
  localparam int IN_LVL_LSB = 4;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  // Input function codes
  localparam logic [3:0] FN_IN_LEVEL_LONG = 4'h0;
  localparam logic [3:0] FN_IN_LEVEL = 4'h1;
  localparam logic [3:0] FN_IN_PWR_ONOFF = 4'h2;
  localparam logic [3:0] FN_IN_SLEEP_WAKE = 4'h3;
  localparam logic [3:0] FN_IN_SLEEP_WAKE_LONG = 4'h4;
  localparam logic [3:0] FN_IN_SLEEP = 4'h5;
  localparam logic [3:0] FN_IN_PWR_ON = 4'h6;
  localparam logic [3:0] FN_IN_WDOG = 4'h7;
  localparam logic [3:0] FN_IN_VSEL_ONE = 4'h8;
  localparam logic [3:0] FN_IN_VSEL_TWO = 4'h9;
  localparam logic [3:0] FN_IN_HWEN_ONE = 4'ha;
  localparam logic [3:0] FN_IN_HWEN_TWO = 4'hb;
  localparam logic [3:0] FN_IN_HWCTL_ONE = 4'hc;
  localparam logic [3:0] FN_IN_HWCTL_TWO = 4'hd;
  localparam logic [3:0] FN_IN_HWCTL_ONE_LONG = 4'he;
  localparam logic [3:0] FN_IN_HWCTL_TWO_LONG = 4'hf;

  // Output function codes
  localparam logic [3:0] FN_OUT_LEVEL = 4'h0;
  localparam logic [3:0] FN_OUT_OSC32K = 4'h1;
  localparam logic [3:0] FN_OUT_ON_STATE = 4'h2;
  localparam logic [3:0] FN_OUT_SLEEP_STATE = 4'h3;
  localparam logic [3:0] FN_OUT_PWR_CHANGE = 4'h4;
  localparam logic [3:0] FN_OUT_DVS_ONE = 4'h8;
  localparam logic [3:0] FN_OUT_DVS_TWO = 4'h9;
  localparam logic [3:0] FN_OUT_EXT_EN_ONE = 4'ha;
  localparam logic [3:0] FN_OUT_EXT_EN_TWO = 4'hb;
  localparam logic [3:0] FN_OUT_SYS_GOOD = 4'hc;
  localparam logic [3:0] FN_OUT_CONV_GOOD = 4'hd;
  localparam logic [3:0] FN_OUT_PWR_CLK = 4'he;
  localparam logic [3:0] FN_OUT_AUX_RESET = 4'hf;
endpackage

// file: rtl/pgp_sync.sv
`timescale 1ns/100ps
module pgp_sync #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pgp_sync_state_t;

  pgp_sync_state_t st_r;
  pgp_sync_state_t st_nxt;

  // The first stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;
endmodule

// file: rtl/pgp_pin.sv
`timescale 1ns/100ps
module pgp_pin (
  input wire logic [15:0] cfg,
  input wire logic lvl,
  input wire logic lvl_prev,
  input wire logic sw_level,
  input wire logic [15:0] src,
  output logic irq_event,
  output logic in_level,
  output logic drive_level,
  output logic drive_en,
  output logic pull_up,
  output logic pull_down,
  output logic long_db,
  output logic [15:0] fn_level
);
  import pgp_pkg::*;

  logic dir;
  logic ena;
  logic pol;
  logic od;
  logic mode;
  logic is_in;
  logic prev_level;
  logic out_val;
  logic drv;
  logic [3:0] fn;

  assign dir = cfg[DIR_POS];
  assign ena = cfg[ENA_POS];
  assign pol = cfg[POL_POS];
  assign od = cfg[OD_POS];
  assign mode = cfg[IRQ_MODE_POS];
  assign fn = cfg[FN_MSB:FN_LSB];

  // Polarity maps pin to logic level
  assign in_level = pol ? lvl : ~lvl;
  assign prev_level = pol ? lvl_prev : ~lvl_prev;
  assign is_in = ena & dir;

  assign irq_event = is_in & (mode ? (lvl ^ lvl_prev) : (in_level & ~prev_level));

  assign out_val = (fn == FN_OUT_LEVEL) ? sw_level : src[fn];
  assign drv = pol ? out_val : ~out_val;
  assign drive_en = ena & ~dir & (od ? ~drv : 1'b1);
  assign drive_level = od ? 1'b0 : drv;

  // Reserved pull code gives no pull
  assign pull_up = (cfg[PULL_MSB:PULL_LSB] == PULL_UP);
  assign pull_down = (cfg[PULL_MSB:PULL_LSB] == PULL_DOWN);

  assign long_db = is_in & ((fn == FN_IN_LEVEL_LONG) | (fn == FN_IN_SLEEP_WAKE_LONG) |
                            (fn == FN_IN_HWCTL_ONE_LONG) | (fn == FN_IN_HWCTL_TWO_LONG));

  for (genvar i = 0; i < 16; i++) begin : g_fn
    assign fn_level[i] = is_in & (fn == 4'(i)) & in_level;
  end
endmodule

// file: rtl/pgp_gpio_pin_control.sv
// Chosen here: the strobed register port.
`timescale 1ns/100ps
// Contract
// - Pull field: none, down, up, reserved
// - Mode zero: single edge set by polarity
// - Mode one: both edges, polarity ignored
// - Bit 11 picks supply domain
// - Bit 10 polarity, non-inverted at reset
// - Bit 9 push-pull or open-drain
// - Bit 7 zero keeps pin tri-stated
// - Function field resets zero; level inputs
// - Input codes 2-6 power and sleep requests
// - Codes 7-9 watchdog and voltage selects
// - Codes 10-15 hardware enables and controls
// - Output 0 software level, 1 slow clock
// - Outputs 2-4 state; 5-7 reserved
// - Outputs 8-11 scaling done, power enables
// - Outputs 12-13 supply and converter good
// - Output 14 fast clock, 15 aux reset
module pgp_gpio_pin_control (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [pgp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pgp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pgp_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic [pgp_pkg::NPIN-1:0] pin_in,
  output logic [pgp_pkg::NPIN-1:0] pin_out,
  output logic [pgp_pkg::NPIN-1:0] pin_oe,
  output logic [pgp_pkg::NPIN-1:0] pin_pull_up,
  output logic [pgp_pkg::NPIN-1:0] pin_pull_down,
  output logic [pgp_pkg::NPIN-1:0] pin_supply_domain,
  output logic [pgp_pkg::NPIN-1:0] pin_long_debounce,
  input wire logic osc_32k_in,
  input wire logic ext_pwr_clk_in,
  input wire logic on_state,
  input wire logic sleep_state,
  input wire logic power_state_change,
  input wire logic dvs_done_one,
  input wire logic dvs_done_two,
  input wire logic ext_power_enable_one,
  input wire logic ext_power_enable_two,
  input wire logic system_supply_good,
  input wire logic converter_power_good,
  input wire logic aux_reset,
  output logic power_onoff_req,
  output logic sleep_wake_req,
  output logic sleep_req,
  output logic power_on_req,
  output logic watchdog_reset,
  output logic voltage_scaling_sel_one,
  output logic voltage_scaling_sel_two,
  output logic hw_enable_one,
  output logic hw_enable_two,
  output logic hw_control_one,
  output logic hw_control_two
);
  import pgp_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0][15:0] ctrl;
    logic [NPIN-1:0] sw_out;
    logic [NPIN-1:0] irq_status;
    logic [NPIN-1:0] irq_mask;
    logic [NPIN-1:0] prev_lvl;
    logic [NPIN-1:0] in_lvl;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
    logic [NPIN-1:0] pull_up;
    logic [NPIN-1:0] pull_dn;
    logic [NPIN-1:0] domain;
    logic [NPIN-1:0] long_db;
    logic [15:0] rdata;
    logic irq;
    logic pwr_onoff;
    logic sleep_wake;
    logic sleep;
    logic pwr_on;
    logic wdog;
    logic vsel_one;
    logic vsel_two;
    logic hwen_one;
    logic hwen_two;
    logic hwctl_one;
    logic hwctl_two;
  } pgp_state_t;

  pgp_state_t st_r;
  pgp_state_t st_nxt;

  logic [NPIN-1:0] pin_sync;
  logic osc_32k_sync;
  logic ext_pwr_clk_sync;
  logic [15:0] out_src;
  logic pin_event [NPIN];
  logic pin_logic [NPIN];
  logic pin_drv [NPIN];
  logic pin_den [NPIN];
  logic pin_pu [NPIN];
  logic pin_pd [NPIN];
  logic pin_ldb [NPIN];
  logic [15:0] pin_fnl [NPIN];
  logic [15:0] fn_any;

  // Pins and the two foreign clocks come from outside this clock domain
  pgp_sync #(
    .W(NPIN + 2)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({ext_pwr_clk_in, osc_32k_in, pin_in}),
    .sync_out({ext_pwr_clk_sync, osc_32k_sync, pin_sync})
  );

  // Output function sources, slow clock through auxiliary reset
  // Clocks are resampled at 25 MHz, so edges carry up to one period of jitter
  always_comb begin
    out_src = '0;
    out_src[FN_OUT_OSC32K] = osc_32k_sync;
    out_src[FN_OUT_ON_STATE] = on_state;
    out_src[FN_OUT_SLEEP_STATE] = sleep_state;
    out_src[FN_OUT_PWR_CHANGE] = power_state_change;
    out_src[FN_OUT_DVS_ONE] = dvs_done_one;
    out_src[FN_OUT_DVS_TWO] = dvs_done_two;
    out_src[FN_OUT_EXT_EN_ONE] = ext_power_enable_one;
    out_src[FN_OUT_EXT_EN_TWO] = ext_power_enable_two;
    out_src[FN_OUT_SYS_GOOD] = system_supply_good;
    out_src[FN_OUT_CONV_GOOD] = converter_power_good;
    out_src[FN_OUT_PWR_CLK] = ext_pwr_clk_sync;
    out_src[FN_OUT_AUX_RESET] = aux_reset;
  end

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    pgp_pin u_pin (
      .cfg(st_r.ctrl[p]),
      .lvl(pin_sync[p]),
      .lvl_prev(st_r.prev_lvl[p]),
      .sw_level(st_r.sw_out[p]),
      .src(out_src),
      .irq_event(pin_event[p]),
      .in_level(pin_logic[p]),
      .drive_level(pin_drv[p]),
      .drive_en(pin_den[p]),
      .pull_up(pin_pu[p]),
      .pull_down(pin_pd[p]),
      .long_db(pin_ldb[p]),
      .fn_level(pin_fnl[p])
    );
  end

  assign fn_any = pin_fnl[0] | pin_fnl[1];

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        PIN2_CTRL_OFS: st_nxt.ctrl[0] = reg_wdata & CTRL_WMASK;
        PIN3_CTRL_OFS: st_nxt.ctrl[1] = reg_wdata & CTRL_WMASK;
        IRQ_MASK_OFS: st_nxt.irq_mask = reg_wdata[NPIN-1:0];
        PIN_LEVEL_OFS: st_nxt.sw_out = reg_wdata[SW_OUT_LSB +: NPIN];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // Write-one-to-clear; a new edge in the same cycle keeps its bit set
    if (reg_wr && reg_addr == IRQ_STATUS_OFS) begin
      st_nxt.irq_status = st_r.irq_status & ~reg_wdata[NPIN-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        PIN2_CTRL_OFS: st_nxt.rdata = st_r.ctrl[0];
        PIN3_CTRL_OFS: st_nxt.rdata = st_r.ctrl[1];
        IRQ_STATUS_OFS: st_nxt.rdata[NPIN-1:0] = st_r.irq_status;
        IRQ_MASK_OFS: st_nxt.rdata[NPIN-1:0] = st_r.irq_mask;
        PIN_LEVEL_OFS: begin
          st_nxt.rdata[SW_OUT_LSB +: NPIN] = st_r.sw_out;
          st_nxt.rdata[IN_LVL_LSB +: NPIN] = st_r.in_lvl;
        end
        default: st_nxt.rdata = '0;
      endcase
    end
    for (int p = 0; p < NPIN; p++) begin
      st_nxt.irq_status[p] = st_nxt.irq_status[p] | pin_event[p];
      st_nxt.prev_lvl[p] = pin_sync[p];
      st_nxt.in_lvl[p] = pin_logic[p];
      st_nxt.pin_out[p] = pin_drv[p];
      st_nxt.pin_oe[p] = pin_den[p];
      st_nxt.pull_up[p] = pin_pu[p];
      st_nxt.pull_dn[p] = pin_pd[p];
      st_nxt.domain[p] = st_r.ctrl[p][DOMAIN_POS];
      st_nxt.long_db[p] = pin_ldb[p];
    end
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
    st_nxt.pwr_onoff = fn_any[FN_IN_PWR_ONOFF];
    st_nxt.sleep_wake = fn_any[FN_IN_SLEEP_WAKE] | fn_any[FN_IN_SLEEP_WAKE_LONG];
    st_nxt.sleep = fn_any[FN_IN_SLEEP];
    st_nxt.pwr_on = fn_any[FN_IN_PWR_ON];
    st_nxt.wdog = fn_any[FN_IN_WDOG];
    st_nxt.vsel_one = fn_any[FN_IN_VSEL_ONE];
    st_nxt.vsel_two = fn_any[FN_IN_VSEL_TWO];
    st_nxt.hwen_one = fn_any[FN_IN_HWEN_ONE];
    st_nxt.hwen_two = fn_any[FN_IN_HWEN_TWO];
    st_nxt.hwctl_one = fn_any[FN_IN_HWCTL_ONE] | fn_any[FN_IN_HWCTL_ONE_LONG];
    st_nxt.hwctl_two = fn_any[FN_IN_HWCTL_TWO] | fn_any[FN_IN_HWCTL_TWO_LONG];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.ctrl[0] <= CTRL_RST;
      st_r.ctrl[1] <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign pin_pull_up = st_r.pull_up;
  assign pin_pull_down = st_r.pull_dn;
  assign pin_supply_domain = st_r.domain;
  assign pin_long_debounce = st_r.long_db;
  assign power_onoff_req = st_r.pwr_onoff;
  assign sleep_wake_req = st_r.sleep_wake;
  assign sleep_req = st_r.sleep;
  assign power_on_req = st_r.pwr_on;
  assign watchdog_reset = st_r.wdog;
  assign voltage_scaling_sel_one = st_r.vsel_one;
  assign voltage_scaling_sel_two = st_r.vsel_two;
  assign hw_enable_one = st_r.hwen_one;
  assign hw_enable_two = st_r.hwen_two;
  assign hw_control_one = st_r.hwctl_one;
  assign hw_control_two = st_r.hwctl_two;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic [15:0] c0;
  logic [15:0] c1;
  assign c0 = st_r.ctrl[0];
  assign c1 = st_r.ctrl[1];

  AST_PULL_DOWN: assert property (
    (c0[PULL_MSB:PULL_LSB] == PULL_DOWN) |=> (st_r.pull_dn[0] && !st_r.pull_up[0]))
    else $error("pull-down select not reflected on pull outputs");

  AST_PULL_RSVD: assert property (
    (c0[PULL_MSB:PULL_LSB] == 2'h3) |=> (!st_r.pull_dn[0] && !st_r.pull_up[0]))
    else $error("reserved pull code enabled a resistor");

  AST_EDGE_RISE: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && !c1[IRQ_MODE_POS] && c1[POL_POS] &&
     pin_sync[1] && !st_r.prev_lvl[1]) |=> st_r.irq_status[1])
    else $error("rising edge missed in single edge mode");

  AST_EDGE_IGNORED: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && !c1[IRQ_MODE_POS] && !c1[POL_POS] &&
     pin_sync[1] && !st_r.prev_lvl[1] && !st_r.irq_status[1]) |=> !st_r.irq_status[1])
    else $error("inactive edge raised interrupt");

  AST_EDGE_BOTH: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && c1[IRQ_MODE_POS] &&
     !pin_sync[1] && st_r.prev_lvl[1]) |=> st_r.irq_status[1])
    else $error("falling edge missed in both edge mode");

  AST_DOMAIN: assert property (
    1'b1 |=> (st_r.domain[1] == $past(st_r.ctrl[1][DOMAIN_POS])))
    else $error("supply domain output mismatch");

  AST_POL_OUT: assert property (
    (c0[ENA_POS] && !c0[DIR_POS] && !c0[POL_POS] && !c0[OD_POS] &&
     c0[FN_MSB:FN_LSB] == FN_OUT_LEVEL) |=> (st_r.pin_oe[0] && st_r.pin_out[0] == !$past(st_r.sw_out[0])))
    else $error("inverted output level wrong");

  AST_OPEN_DRAIN: assert property (
    c0[OD_POS] |=> !st_r.pin_out[0])
    else $error("open drain drove high");

  AST_TRISTATE: assert property (
    !c0[ENA_POS] |=> !st_r.pin_oe[0])
    else $error("disabled pin driven");

  AST_WDOG: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && c1[POL_POS] && c1[FN_MSB:FN_LSB] == FN_IN_WDOG &&
     !c0[ENA_POS]) |=> (watchdog_reset == $past(pin_sync[1])))
    else $error("watchdog input not routed");

  AST_PWR_REQ_INV: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && !c1[POL_POS] && c1[FN_MSB:FN_LSB] == FN_IN_PWR_ONOFF &&
     !c0[ENA_POS]) |=> (power_onoff_req == !$past(pin_sync[1])))
    else $error("inverted power request not routed");

  AST_HWCTL_LONG: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && c1[POL_POS] && !c0[ENA_POS] &&
     c1[FN_MSB:FN_LSB] == FN_IN_HWCTL_ONE_LONG) |=> (hw_control_one == $past(pin_sync[1])))
    else $error("long debounce control input not routed");

  AST_LONG_DB: assert property (
    (c1[ENA_POS] && c1[DIR_POS] && c1[FN_MSB:FN_LSB] == FN_IN_LEVEL_LONG) |=> st_r.long_db[1])
    else $error("long debounce flag missing");

  AST_EXT_EN_OUT: assert property (
    (c0[ENA_POS] && !c0[DIR_POS] && c0[POL_POS] && !c0[OD_POS] &&
     c0[FN_MSB:FN_LSB] == FN_OUT_EXT_EN_ONE) |=> (st_r.pin_out[0] == $past(ext_power_enable_one)))
    else $error("power enable not routed to pin");

  AST_INPUT_NO_DRIVE: assert property (
    c1[DIR_POS] |=> !st_r.pin_oe[1])
    else $error("input pin driven");

  AST_RESERVED: assert property (
    (c0[ENA_POS] && !c0[DIR_POS] && c0[POL_POS] && c0[FN_MSB:FN_LSB] == 4'h5)
    |=> !st_r.pin_out[0])
    else $error("reserved output code drove high");

  AST_READBACK: assert property (
    (reg_wr && reg_addr == PIN3_CTRL_OFS) ##1 (reg_rd && reg_addr == PIN3_CTRL_OFS)
    |=> (reg_rdata == ($past(reg_wdata, 2) & CTRL_WMASK)))
    else $error("control read-back mismatch");

  COV_IRQ: cover property ($rose(irq));
  COV_DRIVE: cover property (st_r.pin_oe[0] && st_r.pin_out[0]);
  COV_CLEAR: cover property (reg_wr && reg_addr == IRQ_STATUS_OFS && st_r.irq_status[0]);
  COV_BOTH_EDGES: cover property (c1[IRQ_MODE_POS] && st_r.irq_status[1]);
  COV_REQUEST: cover property (watchdog_reset);
endmodule

// file: tb/pgp_board.sv
`timescale 1ns/100ps
module pgp_board (
  input wire logic ref_clk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pin_pull_up,
  input wire logic [1:0] pin_pull_down,
  input wire logic [1:0] ext_lvl,
  input wire logic [1:0] ext_en,
  output logic [1:0] pin_in
);
  logic flt_r;
  // A floating pad toggles so it never reads as a settled level
  initial flt_r = 1'b0;
  always @(posedge ref_clk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_lvl[i];
      else if (pin_pull_up[i])
        pin_in[i] = 1'b1;
      else if (pin_pull_down[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = flt_r;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import pgp_pkg::*;
  localparam logic [3:0] ICASE [6] = '{4'h5, 4'h6, 4'h3, 4'h0, 4'hf, 4'h9};
  logic ref_clk;
  logic reset_n;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic irq;
  logic [1:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
  logic [1:0] pin_supply_domain, pin_long_debounce, ext_lvl, ext_en;
  logic [15:0] srcv;
  logic [10:0] reqv;
  logic rd_seen;
  logic [15:0] exp_q[$];
  logic [15:0] d, e;
  logic [31:0] r;
  logic [3:0] t;
  logic lv;
  int err_count, num_checks, b;

  pgp_gpio_pin_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
    .pin_supply_domain(pin_supply_domain), .pin_long_debounce(pin_long_debounce),
    .osc_32k_in(srcv[1]), .ext_pwr_clk_in(srcv[14]), .on_state(srcv[2]),
    .sleep_state(srcv[3]), .power_state_change(srcv[4]), .dvs_done_one(srcv[8]),
    .dvs_done_two(srcv[9]), .ext_power_enable_one(srcv[10]),
    .ext_power_enable_two(srcv[11]), .system_supply_good(srcv[12]),
    .converter_power_good(srcv[13]), .aux_reset(srcv[15]),
    .power_onoff_req(reqv[0]), .sleep_wake_req(reqv[1]), .sleep_req(reqv[2]),
    .power_on_req(reqv[3]), .watchdog_reset(reqv[4]),
    .voltage_scaling_sel_one(reqv[5]), .voltage_scaling_sel_two(reqv[6]),
    .hw_enable_one(reqv[7]), .hw_enable_two(reqv[8]), .hw_control_one(reqv[9]),
    .hw_control_two(reqv[10]));

  pgp_board i_board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_lvl(ext_lvl),
    .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    num_checks++;
    if (g !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, g);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] dv);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] ex);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(ex);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wr_rd(input logic [15:0] a, input logic [15:0] dv, input logic [15:0] ex);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(ex);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [15:0] cfg(input logic dir, input logic [1:0] pl,
    input logic md, input logic pol, input logic od, input logic en, input logic [3:0] fn);
    return {dir, pl, md, 1'b0, pol, od, 1'b0, en, 3'h0, fn};
  endfunction

  function automatic int req_bit(input logic [3:0] c);
    if (c >= 4'hc)
      return 9 + c[0];
    if (c >= 4'h5)
      return c - 3;
    if (c >= 4'h3)
      return 1;
    return (c == 4'h2) ? 0 : -1;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; ten thousand leaves wide margin
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    srcv = 16'h0;
    ext_lvl = 2'h0;
    ext_en = 2'h0;
    void'($urandom(73438));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    wt(1);
    chk("pull_down", 16'h3, pin_pull_down);
    chk("pin_oe", 16'h0, pin_oe);
    rd(PIN2_CTRL_OFS, CTRL_RST);
    rd(PIN3_CTRL_OFS, CTRL_RST);
    rd(IRQ_MASK_OFS, 16'h0);
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom());
      wr_rd(PIN3_CTRL_OFS, d, d & CTRL_WMASK);
      wr(16'h4043, d);
      wr(PIN2_CTRL_OFS, d | 16'h6000);
      rd(PIN3_CTRL_OFS, d & CTRL_WMASK);
      rd(16'h4043, 16'h0);
      wt(2);
      chk("pull_up", 16'(d[14:13] == PULL_UP), pin_pull_up[1]);
      chk("pull_down", 16'(d[14:13] == PULL_DOWN), pin_pull_down[1]);
      chk("pull_rsvd", 16'h0, {pin_pull_up[0], pin_pull_down[0]});
      chk("domain", 16'(d[11]), pin_supply_domain[1]);
    end
    wr(PIN3_CTRL_OFS, CTRL_RST);
    wr(PIN2_CTRL_OFS, CTRL_RST);
    $display("register access done");
    for (int c = 0; c < 16; c++) begin
      r = $urandom();
      @(posedge ref_clk);
      srcv <= r[15:0];
      wr(PIN_LEVEL_OFS, {15'h0, r[0]});
      wr(PIN2_CTRL_OFS, cfg(1'b0, PULL_NONE, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      wt(4);
      e = (c >= 5 && c <= 7) ? 16'h0 : 16'(r[c]);
      chk("pin_out", e, pin_out[0]);
      chk("pin_oe", 16'h1, pin_oe[0]);
    end
    for (int c = 0; c < 16; c++) begin
      wr(PIN_LEVEL_OFS, {15'h0, c[0]});
      wr(PIN2_CTRL_OFS, cfg(1'b0, PULL_NONE, 1'b0, c[1], c[2], c[3], FN_OUT_LEVEL));
      wt(2);
      lv = c[0] ^ ~c[1];
      chk("pin_oe", 16'(c[3] & (c[2] ? ~lv : 1'b1)), pin_oe[0]);
      if (c[3])
        chk("pin_out", 16'(c[2] ? 1'b0 : lv), pin_out[0]);
    end
    wr(PIN2_CTRL_OFS, CTRL_RST);
    $display("output functions done");
    @(posedge ref_clk);
    ext_en <= 2'h2;
    for (int c = 0; c < 32; c++) begin
      r = $urandom();
      @(posedge ref_clk);
      ext_lvl <= {r[0], 1'b0};
      wr(PIN3_CTRL_OFS, cfg(1'b1, PULL_DOWN, 1'b0, c[4], 1'b0, 1'b1, c[3:0]));
      wt(4);
      lv = r[0] ^ ~c[4];
      b = req_bit(c[3:0]);
      e = 16'h0;
      if (b >= 0)
        e[b] = lv;
      chk("requests", e, reqv);
      chk("long_db", 16'(c[3:0] inside {4'h0, 4'h4, 4'he, 4'hf}), pin_long_debounce[1]);
      chk("pin_oe", 16'h0, pin_oe[1]);
      rd(PIN_LEVEL_OFS, {10'h0, lv, 5'h01});
    end
    $display("input functions done");
    wr(IRQ_MASK_OFS, 16'h2);
    for (int c = 0; c < 6; c++) begin
      t = ICASE[c];
      @(posedge ref_clk);
      ext_lvl <= {t[1], 1'b0};
      wr(PIN3_CTRL_OFS, cfg(1'b1, PULL_DOWN, t[3], t[2], 1'b0, 1'b1, FN_IN_LEVEL));
      wt(5);
      wr(IRQ_STATUS_OFS, 16'h3);
      wt(1);
      chk("irq cleared", 16'h0, irq);
      @(posedge ref_clk);
      ext_lvl <= {~t[1], 1'b0};
      wt(5);
      chk("irq", 16'(t[0]), irq);
      rd(IRQ_STATUS_OFS, {14'h0, t[0], 1'b0});
    end
    wr(IRQ_MASK_OFS, 16'h0);
    wt(2);
    chk("irq masked", 16'h0, irq);
    rd(IRQ_STATUS_OFS, 16'h2);
    wr(IRQ_STATUS_OFS, 16'h2);
    rd(IRQ_STATUS_OFS, 16'h0);
    $display("interrupt edges done");
    wt(3);
    summarize();
  end
endmodule
